//--- common/dmac_pkg.sv
package dmac_pkg;
  localparam int NCH = 4;
  localparam int CHW = 2;
  localparam int NFLAG = 7;
  // global register byte addresses
  localparam logic [11:0] A_GCON = 12'h000;
  localparam logic [11:0] A_GSTAT = 12'h004;
  localparam logic [11:0] A_GADDR = 12'h008;
  localparam logic [11:0] A_CRCCON = 12'h00c;
  localparam logic [11:0] A_CRCDAT = 12'h010;
  localparam logic [11:0] A_CH_BASE = 12'h040;
  localparam int CH_SH = 5;
  // per-channel word index inside a 0x20 window
  localparam logic [2:0] R_CTRL = 3'h0;
  localparam logic [2:0] R_SEL = 3'h1;
  localparam logic [2:0] R_FLAG = 3'h2;
  localparam logic [2:0] R_SSA = 3'h3;
  localparam logic [2:0] R_DSA = 3'h4;
  localparam logic [2:0] R_SIZE = 3'h5;
  localparam logic [2:0] R_PTR = 3'h6;
  localparam logic [2:0] R_PAT = 3'h7;
  // global control and status fields
  localparam int G_ON = 15;
  localparam int G_SUSP = 12;
  localparam int G_BUSY = 11;
  localparam int S_DIR = 3;
  localparam int CRC_EN = 7;
  // channel control fields
  localparam int C_EN = 0;
  localparam int C_AUTO = 1;
  localparam int C_CHAIN = 2;
  localparam int C_CSRC = 3;
  localparam int C_STEN = 5;
  localparam int C_ABEN = 6;
  localparam int C_PATEN = 7;
  localparam int C_FORCE = 8;
  localparam int C_ABORT = 9;
  localparam int C_PEND = 15;
  localparam int C_CSIZ = 16;
  // channel event flags
  localparam int F_DONE = 0;
  localparam int F_SEMPTY = 1;
  localparam int F_SHALF = 2;
  localparam int F_DFULL = 3;
  localparam int F_DHALF = 4;
  localparam int F_ABORT = 5;
  localparam int F_ERR = 6;
  localparam logic [7:0] CRC_POLY = 8'h07;
  typedef enum logic [1:0] {ST_IDLE, ST_RD, ST_WR} dmac_state_e;
  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [7:0] wdata;
  } dmac_mreq_s;
endpackage

//--- core/dmac_top.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - master moves data between any mapped locations without the processor
// - four identical channels with auto-incrementing source and destination pointers
// - every channel does memory-to-memory and memory-peripheral moves
// - byte granularity, no alignment needed on either address
// - fixed priority among requesting channels, channel 0 highest
// - transfer started by software force or by an interrupt event
// - one-shot or auto-repeat blocks; a channel may be chained to another
// - any interrupt line selectable as start trigger
// - any interrupt line selectable as abort trigger
// - block may end when moved data matches pattern value
// - flags for done, source empty/half, destination full/half, aborted
// - error flag when address generation is invalid
// - the one crc unit attaches to any chosen channel
// - global enable bit 15, reset zero
// - suspend bit 12 holds off all transfers
// - busy bit 11 reads one while active, zero when idle
// - status bit 3 shows last access was a read
// - status bits 2..0 show most recently active channel
// - read-only register holds address of most recent access
// - unimplemented global bits read zero, writes ignored
module dmac_top
  import dmac_pkg::*;
#(
  parameter int SELW = 8,
  parameter int PW = 16
)(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // system bus master, byte wide
  output dmac_mreq_s mreq,
  input wire logic m_ack,
  input wire logic [7:0] m_rdata,
  // peripheral interrupt lines
  input wire logic [2**SELW-1:0] periph_irq
);

  function automatic logic [CHW-1:0] prio(input logic [NCH-1:0] v);
    prio = '0;
    for (int i = NCH - 1; i >= 0; i--)
    begin
      if (v[i])
        prio = CHW'(i);
    end
  endfunction

  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] x;
    x = c ^ d;
    for (int i = 0; i < 8; i++)
    begin
      x = x[7] ? ((x << 1) ^ CRC_POLY) : (x << 1);
    end
    crc8 = x;
  endfunction

  logic on_r, susp_r, pready_r, pslverr_r;
  logic [31:0] prdata_r, rd_val, last_addr_r;
  logic hit, acc, wr_do, is_ch, last_dir_r, crc_en_r;
  logic [11:0] off;
  logic [CHW-1:0] chn, cur_r, pick, crc_ch_r, last_ch_r;
  logic [2:0] ridx;
  logic [7:0] data_r, crc_r;
  dmac_state_e st_r;
  dmac_mreq_s mreq_r;
  logic [2**SELW-1:0] irq_q_r, rise;
  logic [NCH-1:0] en_r, pend_r;
  logic auto_r [NCH], chain_r [NCH], sten_r [NCH], aben_r [NCH], paten_r [NCH];
  logic [CHW-1:0] csrc_r [NCH];
  logic [7:0] csiz_r [NCH], ccnt_r [NCH], pat_r [NCH];
  logic [SELW-1:0] ssel_r [NCH], asel_r [NCH];
  logic [NFLAG-1:0] flag_r [NCH], fset [NCH];
  logic [31:0] ssa_r [NCH], dsa_r [NCH];
  logic [PW-1:0] ssiz_r [NCH], dsiz_r [NCH], sptr_r [NCH], dptr_r [NCH];
  logic [NCH-1:0] ready, start_ev, abort_ev, step, done_ev, cell_end, err_ev, wsel;
  logic go, bad;

  // apb decode: one wait state so read data comes from a flop
  assign acc = psel && penable;
  assign wr_do = acc && pready_r && pwrite;
  assign off = paddr - A_CH_BASE;
  assign is_ch = (paddr >= A_CH_BASE) && (off[11:CH_SH] < 7'(NCH));
  assign chn = off[CH_SH +: CHW];
  assign ridx = paddr[4:2];
  assign rise = periph_irq & ~irq_q_r;

  always_comb
  begin
    rd_val = '0;
    hit = 1'b1;
    if (is_ch)
    begin
      unique case (ridx)
        R_CTRL:
        begin
          rd_val[C_EN] = en_r[chn];
          rd_val[C_AUTO] = auto_r[chn];
          rd_val[C_CHAIN] = chain_r[chn];
          rd_val[C_CSRC +: CHW] = csrc_r[chn];
          rd_val[C_STEN] = sten_r[chn];
          rd_val[C_ABEN] = aben_r[chn];
          rd_val[C_PATEN] = paten_r[chn];
          rd_val[C_PEND] = pend_r[chn];
          rd_val[C_CSIZ +: 8] = csiz_r[chn];
        end
        R_SEL: rd_val = {16'h0000, 8'(asel_r[chn]), 8'(ssel_r[chn])};
        R_FLAG: rd_val[NFLAG-1:0] = flag_r[chn];
        R_SSA: rd_val = ssa_r[chn];
        R_DSA: rd_val = dsa_r[chn];
        R_SIZE: rd_val = {16'(dsiz_r[chn]), 16'(ssiz_r[chn])};
        R_PTR: rd_val = {16'(dptr_r[chn]), 16'(sptr_r[chn])};
        R_PAT: rd_val[7:0] = pat_r[chn];
      endcase
    end
    else
    begin
      case (paddr)
        A_GCON:
        begin
          rd_val[G_ON] = on_r;
          rd_val[G_SUSP] = susp_r;
          rd_val[G_BUSY] = (st_r != ST_IDLE);
        end
        A_GSTAT:
        begin
          rd_val[S_DIR] = last_dir_r;
          rd_val[2:0] = 3'(last_ch_r);
        end
        A_GADDR: rd_val = last_addr_r;
        A_CRCCON:
        begin
          rd_val[CRC_EN] = crc_en_r;
          rd_val[CHW-1:0] = crc_ch_r;
        end
        A_CRCDAT: rd_val[7:0] = crc_r;
        default: hit = 1'b0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r <= 1'b0;
      prdata_r <= '0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      pready_r <= acc && !pready_r;
      prdata_r <= (acc && !pready_r && !pwrite) ? rd_val : '0;
      pslverr_r <= acc && !pready_r && !hit;
    end
  end

  // global control; only the enable and suspend bits are stored
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      on_r <= 1'b0;
      susp_r <= 1'b0;
    end
    else if (wr_do && !is_ch && paddr == A_GCON)
    begin
      on_r <= pwdata[G_ON];
      susp_r <= pwdata[G_SUSP];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_q_r <= '0;
    else
      irq_q_r <= periph_irq;
  end

  // channel events
  assign ready = pend_r & en_r;
  assign go = on_r && !susp_r && (|ready);
  assign pick = prio(ready);
  // zero sizes would never reach a block end, so they count as invalid addressing
  assign bad = (ssiz_r[pick] == '0) || (dsiz_r[pick] == '0) || (csiz_r[pick] == '0);

  always_comb
  begin
    for (int c = 0; c < NCH; c++)
    begin
      wsel[c] = wr_do && is_ch && (chn == CHW'(c));
      err_ev[c] = (st_r == ST_IDLE) && go && bad && (pick == CHW'(c));
      step[c] = (st_r == ST_WR) && m_ack && (cur_r == CHW'(c)) && en_r[c];
      done_ev[c] = step[c] && (((ssiz_r[c] >= dsiz_r[c]) ?
          (sptr_r[c] + 1'b1 == ssiz_r[c]) : (dptr_r[c] + 1'b1 == dsiz_r[c])) ||
          (paten_r[c] && data_r == pat_r[c]));
      cell_end[c] = step[c] && (ccnt_r[c] + 8'h01 == csiz_r[c]);
      abort_ev[c] = (wsel[c] && ridx == R_CTRL && pwdata[C_ABORT]) ||
          (aben_r[c] && rise[asel_r[c]]);
      fset[c] = '0;
      fset[c][F_DONE] = done_ev[c];
      fset[c][F_SEMPTY] = step[c] && (sptr_r[c] + 1'b1 == ssiz_r[c]);
      fset[c][F_SHALF] = step[c] && (sptr_r[c] + 1'b1 == (ssiz_r[c] >> 1));
      fset[c][F_DFULL] = step[c] && (dptr_r[c] + 1'b1 == dsiz_r[c]);
      fset[c][F_DHALF] = step[c] && (dptr_r[c] + 1'b1 == (dsiz_r[c] >> 1));
      fset[c][F_ABORT] = abort_ev[c];
      fset[c][F_ERR] = err_ev[c];
    end
    for (int c = 0; c < NCH; c++)
    begin
      start_ev[c] = on_r && ((wsel[c] && ridx == R_CTRL && pwdata[C_FORCE]) ||
          (sten_r[c] && rise[ssel_r[c]]) ||
          (chain_r[c] && done_ev[csrc_r[c]]));
    end
  end

  // channel state: register writes first, hardware events override them
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int c = 0; c < NCH; c++)
      begin
        en_r[c] <= 1'b0;
        auto_r[c] <= 1'b0;
        chain_r[c] <= 1'b0;
        csrc_r[c] <= '0;
        sten_r[c] <= 1'b0;
        aben_r[c] <= 1'b0;
        paten_r[c] <= 1'b0;
        pend_r[c] <= 1'b0;
        csiz_r[c] <= '0;
        ccnt_r[c] <= '0;
        pat_r[c] <= '0;
        ssel_r[c] <= '0;
        asel_r[c] <= '0;
        flag_r[c] <= '0;
        ssa_r[c] <= '0;
        dsa_r[c] <= '0;
        ssiz_r[c] <= '0;
        dsiz_r[c] <= '0;
        sptr_r[c] <= '0;
        dptr_r[c] <= '0;
      end
    end
    else
    begin
      for (int c = 0; c < NCH; c++)
      begin
        if (wsel[c])
        begin
          unique case (ridx)
            R_CTRL:
            begin
              en_r[c] <= pwdata[C_EN];
              auto_r[c] <= pwdata[C_AUTO];
              chain_r[c] <= pwdata[C_CHAIN];
              csrc_r[c] <= pwdata[C_CSRC +: CHW];
              sten_r[c] <= pwdata[C_STEN];
              aben_r[c] <= pwdata[C_ABEN];
              paten_r[c] <= pwdata[C_PATEN];
              csiz_r[c] <= pwdata[C_CSIZ +: 8];
            end
            R_SEL:
            begin
              ssel_r[c] <= pwdata[SELW-1:0];
              asel_r[c] <= pwdata[8 +: SELW];
            end
            R_SSA: ssa_r[c] <= pwdata;
            R_DSA: dsa_r[c] <= pwdata;
            R_SIZE:
            begin
              ssiz_r[c] <= pwdata[PW-1:0];
              dsiz_r[c] <= pwdata[16 +: PW];
            end
            R_PAT: pat_r[c] <= pwdata[7:0];
            default: ;
          endcase
        end
        // set wins over a simultaneous write-one-to-clear
        flag_r[c] <= (flag_r[c] & ~((wsel[c] && ridx == R_FLAG) ?
            pwdata[NFLAG-1:0] : '0)) | fset[c];
        if (abort_ev[c] || err_ev[c])
        begin
          en_r[c] <= 1'b0;
          pend_r[c] <= 1'b0;
          sptr_r[c] <= '0;
          dptr_r[c] <= '0;
          ccnt_r[c] <= '0;
        end
        else
        begin
          if (step[c])
          begin
            // each pointer wraps at its own size
            sptr_r[c] <= (sptr_r[c] + 1'b1 == ssiz_r[c]) ? '0 : sptr_r[c] + 1'b1;
            dptr_r[c] <= (dptr_r[c] + 1'b1 == dsiz_r[c]) ? '0 : dptr_r[c] + 1'b1;
            ccnt_r[c] <= cell_end[c] ? '0 : ccnt_r[c] + 8'h01;
            if (cell_end[c])
              pend_r[c] <= 1'b0;
          end
          if (done_ev[c])
          begin
            sptr_r[c] <= '0;
            dptr_r[c] <= '0;
            ccnt_r[c] <= '0;
            pend_r[c] <= 1'b0;
            en_r[c] <= auto_r[c];
          end
          if (start_ev[c])
            pend_r[c] <= 1'b1;
        end
      end
    end
  end

  // engine: one byte per read/write pair, so any alignment works
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r <= ST_IDLE;
      mreq_r <= '0;
      cur_r <= '0;
      data_r <= '0;
      last_ch_r <= '0;
      last_dir_r <= 1'b0;
      last_addr_r <= '0;
    end
    else
    begin
      unique case (st_r)
        ST_IDLE:
        begin
          if (go && !bad)
          begin
            st_r <= ST_RD;
            cur_r <= pick;
            mreq_r <= {1'b1, 1'b0, ssa_r[pick] + 32'(sptr_r[pick]), 8'h00};
            last_ch_r <= pick;
            last_dir_r <= 1'b1;
            last_addr_r <= ssa_r[pick] + 32'(sptr_r[pick]);
          end
        end
        ST_RD:
        begin
          if (m_ack)
          begin
            data_r <= m_rdata;
            // a disable or abort during the read drops the write half
            if (on_r && en_r[cur_r])
            begin
              st_r <= ST_WR;
              mreq_r <= {1'b1, 1'b1, dsa_r[cur_r] + 32'(dptr_r[cur_r]), m_rdata};
              last_dir_r <= 1'b0;
              last_addr_r <= dsa_r[cur_r] + 32'(dptr_r[cur_r]);
            end
            else
            begin
              st_r <= ST_IDLE;
              mreq_r.req <= 1'b0;
            end
          end
        end
        ST_WR:
        begin
          if (m_ack)
          begin
            st_r <= ST_IDLE;
            mreq_r.req <= 1'b0;
          end
        end
      endcase
    end
  end

  // crc tap on the read data of the selected channel
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      crc_en_r <= 1'b0;
      crc_ch_r <= '0;
      crc_r <= '0;
    end
    else
    begin
      if (wr_do && !is_ch && paddr == A_CRCCON)
      begin
        crc_en_r <= pwdata[CRC_EN];
        crc_ch_r <= pwdata[CHW-1:0];
      end
      if (wr_do && !is_ch && paddr == A_CRCDAT)
        crc_r <= pwdata[7:0];
      else if (crc_en_r && st_r == ST_RD && m_ack && cur_r == crc_ch_r)
        crc_r <= crc8(crc_r, m_rdata);
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign mreq = mreq_r;

  sequence s_issue_rd;
    (st_r == ST_IDLE) ##1 (st_r == ST_RD);
  endsequence
  property p_off_no_issue;
    @(posedge pclk) disable iff (!presetn) (st_r == ST_IDLE && !on_r) |=> !mreq_r.req;
  endproperty
  a_off_no_issue: assert property (p_off_no_issue) else $error("access issued while disabled");
  property p_susp_hold;
    @(posedge pclk) disable iff (!presetn) (st_r == ST_IDLE && susp_r) |=> st_r == ST_IDLE;
  endproperty
  a_susp_hold: assert property (p_susp_hold) else $error("transfer started in suspend");
  property p_req_held;
    @(posedge pclk) disable iff (!presetn)
      (mreq_r.req && !m_ack) |=> mreq_r.req && $stable(mreq_r.addr) && $stable(mreq_r.we);
  endproperty
  a_req_held: assert property (p_req_held) else $error("bus request dropped early");
  property p_last_rd;
    @(posedge pclk) disable iff (!presetn)
      s_issue_rd |-> last_dir_r && !mreq_r.we && last_addr_r == mreq_r.addr;
  endproperty
  a_last_rd: assert property (p_last_rd) else $error("last access record wrong");
  property p_rd_then_wr;
    @(posedge pclk) disable iff (!presetn)
      (st_r == ST_RD && m_ack && on_r && en_r[cur_r]) |=> st_r == ST_WR && mreq_r.we
        && mreq_r.wdata == $past(m_rdata) && !last_dir_r;
  endproperty
  a_rd_then_wr: assert property (p_rd_then_wr) else $error("read not followed by write");
  property p_prio;
    @(posedge pclk) disable iff (!presetn)
      (st_r == ST_IDLE && go && !bad) |=> cur_r == $past(pick) && last_ch_r == cur_r;
  endproperty
  a_prio: assert property (p_prio) else $error("wrong channel granted");
  property p_busy;
    @(posedge pclk) disable iff (!presetn) mreq_r.req |-> st_r != ST_IDLE;
  endproperty
  a_busy: assert property (p_busy) else $error("access while not busy");
  property p_abort2;
    @(posedge pclk) disable iff (!presetn) abort_ev[2] |=> !en_r[2] && !pend_r[2] && flag_r[2][F_ABORT];
  endproperty
  a_abort2: assert property (p_abort2) else $error("abort did not stop channel");
  property p_apb_wait;
    @(posedge pclk) disable iff (!presetn) (acc && !pready_r) |=> pready_r;
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("apb answer late");

endmodule
`default_nettype wire

//--- verif/dmac_mem.sv
`timescale 1ns/1ps
`default_nettype none
module dmac_mem
  import dmac_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // byte bus from the block
  input wire dmac_mreq_s mreq,
  output logic m_ack,
  output logic [7:0] m_rdata,
  // wait cycles before each answer
  input wire logic [7:0] lat
);
  logic [7:0] mem [256];
  logic [7:0] cnt;
  logic [31:0] log_a [64];
  int n_acc = 0;

  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i) ^ 8'h5a;
  end

  // read data only means something in the ack cycle; held while a request waits, toggled after an ack and while idle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      m_ack <= 1'b0;
      m_rdata <= 8'ha5;
      cnt <= 8'h00;
    end
    else if (m_ack)
    begin
      m_ack <= 1'b0;
      m_rdata <= ~m_rdata;
    end
    else if (mreq.req && cnt >= lat)
    begin
      m_ack <= 1'b1;
      cnt <= 8'h00;
      log_a[n_acc % 64] <= mreq.addr;
      n_acc <= n_acc + 1;
      if (mreq.we)
        mem[mreq.addr[7:0]] <= mreq.wdata;
      else
        m_rdata <= mem[mreq.addr[7:0]];
    end
    else if (mreq.req)
      cnt <= cnt + 8'h01;
    else
      m_rdata <= ~m_rdata;
  end
endmodule
`default_nettype wire

//--- verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import dmac_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  dmac_mreq_s mreq;
  logic m_ack;
  logic [7:0] m_rdata;
  logic [255:0] irq = '0;
  logic [7:0] lat = 8'h00;
  logic [31:0] rd;
  logic er;
  logic [7:0] crc;
  int n_mismatch = 0;
  int n_checks = 0;
  int k;
  int k2;

  always #2.5 pclk = ~pclk;

  dmac_top #(.SELW(8), .PW(16)) u_dmac_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mreq(mreq), .m_ack(m_ack), .m_rdata(m_rdata), .periph_irq(irq)
  );

  dmac_mem u_dmac_mem (
    .pclk(pclk), .presetn(presetn), .mreq(mreq), .m_ack(m_ack), .m_rdata(m_rdata), .lat(lat)
  );

  task give_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task ck(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // request stands until the rising edge that samples pready high
  task xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 40)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 40)
      ck("pready", 32'h1, {31'h0, pready});
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask

  task rc(input string nm, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0);
    ck(nm, e, rd & m);
  endtask

  task ckm(input string nm, input logic [7:0] a, input logic [7:0] e);
    ck(nm, {24'h0, e}, {24'h0, u_dmac_mem.mem[a]});
  endtask

  task endt(input string s);
    $display("test %s done", s);
  endtask

  function automatic logic [11:0] ca(input int c, input logic [2:0] r);
    return A_CH_BASE + 12'(c << CH_SH) + {7'h00, r, 2'b00};
  endfunction

  function automatic logic [7:0] pat(input logic [7:0] a);
    return a ^ 8'h5a;
  endfunction

  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] v;
    v = c ^ b;
    for (int i = 0; i < 8; i++)
      v = v[7] ? ((v << 1) ^ CRC_POLY) : (v << 1);
    return v;
  endfunction

  // control goes last so the channel never starts half programmed
  task setch(input int c, input logic [31:0] ctl, input logic [31:0] sel,
    input logic [31:0] sa, input logic [31:0] da, input logic [31:0] sz);
    wr(ca(c, R_FLAG), 32'h7f);
    wr(ca(c, R_SEL), sel);
    wr(ca(c, R_SSA), sa);
    wr(ca(c, R_DSA), da);
    wr(ca(c, R_SIZE), sz);
    wr(ca(c, R_CTRL), ctl);
  endtask

  task waitf(input int c, input logic [31:0] m);
    for (int i = 0; i < 200; i++)
    begin
      xfer(ca(c, R_FLAG), 1'b0, 32'h0);
      if ((rd & m) != 32'h0)
        break;
    end
    ck("flag_wait", m, rd & m);
  endtask

  task wacc(input int n);
    for (int i = 0; i < 300 && u_dmac_mem.n_acc < n; i++)
      @(posedge pclk);
  endtask

  task pulse(input int n);
    @(posedge pclk);
    irq[n] <= 1'b1;
    @(posedge pclk);
    irq[n] <= 1'b0;
  endtask

  initial
  begin
    #200000;
    n_mismatch++;
    $display("watchdog expired");
    give_verdict();
  end

  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rc("gcon_rst", A_GCON, '1, 32'h0);
    rc("gstat_rst", A_GSTAT, '1, 32'h0);
    rc("gaddr_rst", A_GADDR, '1, 32'h0);
    wr(A_GCON, 32'hffff_ffff);
    rc("gcon_rsvd", A_GCON, '1, 32'h0000_9000);
    wr(A_GSTAT, 32'hffff_ffff);
    rc("gstat_ro", A_GSTAT, '1, 32'h0);
    xfer(12'h020, 1'b0, 32'h0);
    ck("unmapped", 32'h1, {31'h0, er});
    wr(A_GCON, 32'h0000_8000);
    endt("registers");
    lat <= 8'd20;
    setch(1, 32'h0005_0101, 32'h0, 32'h13, 32'h81, 32'h0005_0005);
    rc("busy", A_GCON, '1, 32'h0000_8800);
    waitf(1, 32'h1);
    for (int i = 0; i < 6; i++)
      ckm("copy", 8'h81 + 8'(i), i < 5 ? pat(8'h13 + 8'(i)) : pat(8'h86));
    rc("flags", ca(1, R_FLAG), '1, 32'h1f);
    rc("last_ch", A_GSTAT, '1, 32'h1);
    rc("last_adr", A_GADDR, '1, 32'h85);
    rc("one_shot", ca(1, R_CTRL), '1, 32'h0005_0000);
    rc("ptr_end", ca(1, R_PTR), '1, 32'h0);
    wr(ca(1, R_FLAG), 32'h7f);
    rc("w1c", ca(1, R_FLAG), '1, 32'h0);
    lat <= 8'd0;
    endt("copy");
    setch(3, 32'h0001_0021, 32'd200, 32'h20, 32'ha0, 32'h0002_0002);
    pulse(201);
    repeat (20) @(posedge pclk);
    rc("no_trig", ca(3, R_PTR), '1, 32'h0);
    k = u_dmac_mem.n_acc;
    pulse(200);
    wacc(k + 2);
    rc("trig_ptr", ca(3, R_PTR), '1, 32'h0001_0001);
    pulse(200);
    waitf(3, 32'h1);
    ckm("trig", 8'ha1, pat(8'h21));
    endt("trigger");
    wr(A_GCON, 32'h0000_9000);
    setch(2, 32'h0002_0101, 32'h0, 32'h40, 32'hc0, 32'h0002_0002);
    setch(0, 32'h0002_0101, 32'h0, 32'h50, 32'hd0, 32'h0002_0002);
    k = u_dmac_mem.n_acc;
    repeat (20) @(posedge pclk);
    ck("susp_idle", 32'(k), 32'(u_dmac_mem.n_acc));
    wr(A_GCON, 32'h0000_8000);
    waitf(2, 32'h1);
    ck("prio_hi", 32'h50, u_dmac_mem.log_a[k % 64]);
    ck("prio_lo", 32'h40, u_dmac_mem.log_a[(k + 4) % 64]);
    endt("priority");
    lat <= 8'd10;
    k = u_dmac_mem.n_acc;
    setch(2, 32'h0004_0101, 32'h0, 32'h60, 32'he0, 32'h0004_0004);
    wacc(k + 1);
    wr(A_GCON, 32'h0000_9000);
    repeat (40) @(posedge pclk);
    k2 = u_dmac_mem.n_acc;
    ck("susp_pair", 32'h0, 32'((k2 - k) % 2));
    repeat (40) @(posedge pclk);
    ck("susp_hold", 32'(k2), 32'(u_dmac_mem.n_acc));
    wr(A_GCON, 32'h0000_8000);
    waitf(2, 32'h1);
    ckm("resume", 8'he3, pat(8'h63));
    endt("suspend");
    k = u_dmac_mem.n_acc;
    setch(2, 32'h0008_0141, 32'h0000_0700, 32'h30, 32'hb0, 32'h0008_0008);
    wacc(k + 2);
    pulse(7);
    waitf(2, 32'h20);
    rc("abort_flags", ca(2, R_FLAG), 32'h21, 32'h20);
    rc("abort_en", ca(2, R_CTRL), 32'h1, 32'h0);
    ck("abort_cut", 32'h1, 32'(u_dmac_mem.n_acc - k < 16));
    rc("abort_ch", A_GSTAT, 32'h7, 32'h2);
    k = u_dmac_mem.n_acc;
    setch(2, 32'h0008_0101, 32'h0, 32'h30, 32'hb0, 32'h0008_0008);
    wacc(k + 2);
    wr(ca(2, R_CTRL), 32'h0000_0200);
    rc("sw_abort", ca(2, R_FLAG), 32'h21, 32'h20);
    lat <= 8'd0;
    endt("abort");
    wr(ca(0, R_PAT), {24'h0, pat(8'h92)});
    setch(0, 32'h0006_0181, 32'h0, 32'h90, 32'h10, 32'h0006_0006);
    waitf(0, 32'h1);
    ckm("pat_last", 8'h12, pat(8'h92));
    ckm("pat_stop", 8'h13, pat(8'h13));
    endt("pattern");
    k = u_dmac_mem.n_acc;
    setch(1, 32'h0001_0101, 32'h0, 32'h0, 32'h10, 32'h0001_0000);
    waitf(1, 32'h40);
    ck("err_quiet", 32'(k), 32'(u_dmac_mem.n_acc));
    endt("error");
    setch(1, 32'h0002_0005, 32'h0, 32'h08, 32'h28, 32'h0002_0002);
    setch(0, 32'h0002_0103, 32'h0, 32'h04, 32'h24, 32'h0002_0002);
    waitf(1, 32'h1);
    ckm("chain", 8'h29, pat(8'h09));
    rc("auto_en", ca(0, R_CTRL), 32'h1, 32'h1);
    endt("chain");
    wr(A_CRCDAT, 32'h0);
    wr(A_CRCCON, 32'h0000_0083);
    setch(3, 32'h0003_0101, 32'h0, 32'h38, 32'h58, 32'h0003_0003);
    waitf(3, 32'h1);
    crc = 8'h00;
    for (int i = 0; i < 3; i++)
      crc = crc8(crc, pat(8'h38 + 8'(i)));
    rc("crc", A_CRCDAT, 32'hff, {24'h0, crc});
    endt("crc");
    lat <= 8'd10;
    k = u_dmac_mem.n_acc;
    setch(2, 32'h0004_0101, 32'h0, 32'h70, 32'hf0, 32'h0004_0004);
    wacc(k + 1);
    wr(A_GCON, 32'h0);
    repeat (40) @(posedge pclk);
    k2 = u_dmac_mem.n_acc;
    rc("off_busy", A_GCON, '1, 32'h0);
    repeat (40) @(posedge pclk);
    ck("off_hold", 32'(k2), 32'(u_dmac_mem.n_acc));
    endt("disable");
    give_verdict();
  end
endmodule
`default_nettype wire
